// ---- core/abw_watch.sv ----
module abw_watch import abw_pkg::*; #(
    parameter int AW = ADDR_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // break setup word
    input wire logic break_setup_data_out,
    input wire logic [WORD_W-1:0] setup_word,
    // virtual reference
    input wire logic ref_valid,
    input wire logic [AW-1:0] virtual_reference_address,
    input wire logic ref_fetch,
    input wire logic ref_read,
    input wire logic ref_write,
    input wire logic ref_user,
    // microcode controls
    input wire logic next_instruction_dispatch,
    input wire logic instruction_abort,
    input wire logic load_processor_flags,
    input wire logic flags_inhibit_bit,
    // memory unit qualifiers
    output logic page_address_condition,
    output logic illegal_entry_qualifier,
    // flag state and trap path enable
    output logic break_inhibit_flag,
    output logic break_suppress_cycle_flag,
    output logic trap_path_enable,
    // interrupt
    output logic irq
);
    // ****************************************
    // declarations
    // ****************************************
    abw_bus_t bus_q;
    logic [3:0] ctrl_q;
    logic [AW-1:0] addr_q;
    logic inh_q;
    logic cyc_q;
    logic pac_q;
    logic [EV_W-1:0] stat_q;
    logic [EV_W-1:0] mask_q;
    logic [31:0] rdat_q;
    logic [31:0] rdat_d;
    logic hit;
    logic fire;
    logic supp;
    logic bus_req;
    logic wr_go;
    logic rd_go;
    logic [EV_W-1:0] ev;
    logic [SEC_W-1:0] sec_unused;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] lane_merge(
        input logic [31:0] old,
        input logic [31:0] nw,
        input logic [3:0] sel
    );
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic sel_bit(
        input logic [WORD_W-1:0] w,
        input int n
    );
        return w[abw_bit(n)];
    endfunction

    // ****************************************
    // wishbone slave
    // ****************************************
    assign bus_req = wb_cyc_i & wb_stb_i & (bus_q == ABW_IDLE);
    assign wr_go = bus_req & wb_we_i;
    assign rd_go = bus_req & ~wb_we_i;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bus_q <= ABW_IDLE;
        end else begin
            case (bus_q)
                ABW_IDLE: begin
                    if (bus_req) begin
                        bus_q <= ABW_ACK;
                    end
                end
                ABW_ACK: begin
                    bus_q <= ABW_IDLE;
                end
                default: begin
                    bus_q <= ABW_IDLE;
                end
            endcase
        end
    end

    assign wb_ack_o = (bus_q == ABW_ACK);

    // read mux, unmapped reads zero
    always_comb begin
        rdat_d = 32'h00000000;
        case (wb_adr_i)
            OFS_CTRL: rdat_d[3:0] = ctrl_q;
            OFS_ADDR: rdat_d[AW-1:0] = addr_q;
            OFS_FLAGS: begin
                rdat_d[FLG_INH] = inh_q;
                rdat_d[FLG_CYC] = cyc_q;
            end
            OFS_STAT: rdat_d[EV_W-1:0] = stat_q;
            OFS_MASK: rdat_d[EV_W-1:0] = mask_q;
            default: rdat_d = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdat_q <= 32'h00000000;
        end else if (rd_go) begin
            rdat_q <= rdat_d;
        end
    end

    assign wb_dat_o = rdat_q;

    // ****************************************
    // break conditions
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_q <= CTRL_RST;
            addr_q <= ADDR_RST;
        end else if (break_setup_data_out) begin
            ctrl_q[CTL_FETCH] <= sel_bit(setup_word, BIT_FETCH);
            ctrl_q[CTL_READ] <= sel_bit(setup_word, BIT_READ);
            ctrl_q[CTL_WRITE] <= sel_bit(setup_word, BIT_WRITE);
            ctrl_q[CTL_USER] <= sel_bit(setup_word, BIT_USER);
            addr_q <= setup_word[abw_bit(BIT_ADDR_LO) -: AW];
        end else if (wr_go && wb_adr_i == OFS_CTRL) begin
            ctrl_q <= 4'(lane_merge(32'(ctrl_q), wb_dat_i, wb_sel_i));
        end else if (wr_go && wb_adr_i == OFS_ADDR) begin
            addr_q <= AW'(lane_merge(32'(addr_q), wb_dat_i, wb_sel_i));
        end
    end

    // section number field, top of the address
    assign sec_unused = addr_q[AW-1 -: SEC_W];

    // ****************************************
    // comparator
    // ****************************************
    abw_match #(
        .AW(AW)
    ) u_match (
        .ref_addr(virtual_reference_address),
        .ref_fetch(ref_fetch),
        .ref_read(ref_read),
        .ref_write(ref_write),
        .ref_user(ref_user),
        .brk_addr(addr_q),
        .en_fetch(ctrl_q[CTL_FETCH]),
        .en_read(ctrl_q[CTL_READ]),
        .en_write(ctrl_q[CTL_WRITE]),
        .en_user(ctrl_q[CTL_USER]),
        .hit(hit)
    );

    assign fire = ref_valid & hit & ~inh_q & ~cyc_q;
    assign supp = ref_valid & hit & (inh_q | cyc_q);

    // ****************************************
    // page fault qualifiers
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pac_q <= 1'b0;
        end else begin
            pac_q <= fire;
        end
    end

    // both asserted together from one flop
    assign page_address_condition = pac_q;
    assign illegal_entry_qualifier = pac_q;

    // ****************************************
    // inhibit and suppress flags
    // ****************************************
    assign trap_path_enable = instruction_abort;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            inh_q <= 1'b0;
            cyc_q <= 1'b0;
        end else if (trap_path_enable) begin
            inh_q <= cyc_q;
            cyc_q <= 1'b0;
        end else if (next_instruction_dispatch) begin
            cyc_q <= inh_q;
            inh_q <= 1'b0;
        end else if (load_processor_flags) begin
            inh_q <= flags_inhibit_bit;
        end
    end

    assign break_inhibit_flag = inh_q;
    assign break_suppress_cycle_flag = cyc_q;

    // ****************************************
    // interrupt status and mask
    // ****************************************
    assign ev[EV_HIT] = fire;
    assign ev[EV_SUPP] = supp;

    // set wins over the read clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stat_q <= '0;
        end else if (rd_go && wb_adr_i == OFS_STAT) begin
            stat_q <= ev;
        end else begin
            stat_q <= stat_q | ev;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mask_q <= MASK_RST;
        end else if (wr_go && wb_adr_i == OFS_MASK && wb_sel_i[0]) begin
            mask_q <= wb_dat_i[EV_W-1:0];
        end
    end

    assign irq = |(stat_q & mask_q);
endmodule // abw_watch

// ---- core/abw_pkg.sv ----
package abw_pkg;
    // ****************************************
    // word layout, bit 0 is the msb of 36
    // ****************************************
    localparam int WORD_W = 36;
    localparam int ADDR_W = 23;
    localparam int SEC_W = 5;
    localparam int BIT_FETCH = 9;
    localparam int BIT_READ = 10;
    localparam int BIT_WRITE = 11;
    localparam int BIT_USER = 12;
    localparam int BIT_ADDR_LO = 13;
    localparam int BIT_INH = 8;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_ADDR = 8'h04;
    localparam logic [7:0] OFS_FLAGS = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0c;
    localparam logic [7:0] OFS_MASK = 8'h10;
    localparam int CTL_FETCH = 0;
    localparam int CTL_READ = 1;
    localparam int CTL_WRITE = 2;
    localparam int CTL_USER = 3;
    localparam int FLG_INH = 0;
    localparam int FLG_CYC = 1;
    localparam int EV_HIT = 0;
    localparam int EV_SUPP = 1;
    localparam int EV_W = 2;
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_RST = 23'h000000;
    localparam logic [EV_W-1:0] MASK_RST = 2'h0;
    // ****************************************
    // bus slave states
    // ****************************************
    typedef enum logic [1:0] {
        ABW_IDLE = 2'b01,
        ABW_ACK = 2'b10
    } abw_bus_t;
    // ****************************************
    // helpers
    // ****************************************
    function automatic int abw_bit(input int n);
        return WORD_W - 1 - n;
    endfunction
endpackage

// ---- core/abw_match.sv ----
module abw_match import abw_pkg::*; #(
    parameter int AW = ADDR_W
) (
    // reference
    input wire logic [AW-1:0] ref_addr,
    input wire logic ref_fetch,
    input wire logic ref_read,
    input wire logic ref_write,
    input wire logic ref_user,
    // conditions
    input wire logic [AW-1:0] brk_addr,
    input wire logic en_fetch,
    input wire logic en_read,
    input wire logic en_write,
    input wire logic en_user,
    // result
    output logic hit
);
    logic type_ok;
    logic qual_ok;

    // reference type selected independently
    assign type_ok = (en_fetch & ref_fetch) | (en_read & ref_read) | (en_write & ref_write);
    // address, write and user all compare
    assign qual_ok = (ref_write == en_write) & (ref_user == en_user);
    assign hit = type_ok & qual_ok & (ref_addr == brk_addr);
endmodule // abw_match

// ---- verif/abw_watch_monitor.sv ----
module abw_watch_monitor (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // watched ports
    input wire logic ref_valid,
    input wire logic next_instruction_dispatch,
    input wire logic instruction_abort,
    input wire logic load_processor_flags,
    input wire logic flags_inhibit_bit,
    input wire logic page_address_condition,
    input wire logic illegal_entry_qualifier,
    input wire logic break_inhibit_flag,
    input wire logic break_suppress_cycle_flag,
    input wire logic trap_path_enable
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    a_qual_pair: assert property (page_address_condition == illegal_entry_qualifier)
        else $error("qualifiers differ");
    a_qual_cause: assert property (page_address_condition |-> $past(ref_valid))
        else $error("qualifier without reference");
    a_inh_blocks: assert property (break_inhibit_flag |=> !page_address_condition)
        else $error("break while inhibited");
    a_sup_blocks: assert property (break_suppress_cycle_flag |=> !page_address_condition)
        else $error("break while suppressed");
    a_dispatch_move: assert property (next_instruction_dispatch && !instruction_abort |=>
        break_suppress_cycle_flag == $past(break_inhibit_flag) && !break_inhibit_flag)
        else $error("dispatch flag move wrong");
    a_abort_copy: assert property (instruction_abort |=>
        break_inhibit_flag == $past(break_suppress_cycle_flag) && !break_suppress_cycle_flag)
        else $error("abort flag copy wrong");
    a_trap_path: assert property (trap_path_enable == instruction_abort)
        else $error("trap path wrong");
    a_load_flags: assert property (load_processor_flags && !next_instruction_dispatch &&
        !instruction_abort |=> break_inhibit_flag == $past(flags_inhibit_bit))
        else $error("load flags wrong");
    a_inh_source: assert property ($rose(break_inhibit_flag) |->
        $past(load_processor_flags && flags_inhibit_bit) || $past(instruction_abort))
        else $error("inhibit set without cause");
    c_break: cover property (page_address_condition);
    c_blocked: cover property (break_suppress_cycle_flag && ref_valid);
    c_abort: cover property (instruction_abort && break_suppress_cycle_flag);
endmodule // abw_watch_monitor

bind abw_watch abw_watch_monitor u_mon (.clk, .rst_n, .ref_valid, .next_instruction_dispatch,
    .instruction_abort, .load_processor_flags, .flags_inhibit_bit, .page_address_condition,
    .illegal_entry_qualifier, .break_inhibit_flag, .break_suppress_cycle_flag, .trap_path_enable);

// ---- verif/abw_mem_model.sv ----
module abw_mem_model import abw_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // break qualifiers
    input wire logic page_address_condition,
    input wire logic illegal_entry_qualifier,
    // fault report
    output logic page_fail_hold,
    output logic [WORD_W-1:0] pf_word
);
    // break fail code, value arbitrary
    localparam logic [WORD_W-1:0] PF_BRK = 36'h0000000a1;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            page_fail_hold <= 1'b0;
            pf_word <= 36'h0;
        end else begin
            page_fail_hold <= page_address_condition && illegal_entry_qualifier;
            pf_word <= (page_address_condition && illegal_entry_qualifier) ? PF_BRK : ~pf_word;
        end
    end
endmodule // abw_mem_model

// ---- verif/tb_abw_watch.sv ----
module tb_abw_watch import abw_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc, stb, we, setup, rv, rf, rr, rw, ru, disp, abrt, ldf, fib;
    logic ack, pac, ill, inh, sup, trap, irq, hold;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, dat_o;
    logic [WORD_W-1:0] sw, pfw;
    logic [ADDR_W-1:0] va;
    int fail_count = 0;
    int total_checks = 0;
    always #2.5 clk = ~clk;
    abw_watch uut (.clk, .rst_n, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .break_setup_data_out(setup),
        .setup_word(sw), .ref_valid(rv), .virtual_reference_address(va), .ref_fetch(rf), .ref_read(rr),
        .ref_write(rw), .ref_user(ru), .next_instruction_dispatch(disp), .instruction_abort(abrt),
        .load_processor_flags(ldf), .flags_inhibit_bit(fib), .page_address_condition(pac),
        .illegal_entry_qualifier(ill), .break_inhibit_flag(inh), .break_suppress_cycle_flag(sup),
        .trap_path_enable(trap), .irq);
    abw_mem_model u_mem (.clk, .rst_n, .page_address_condition(pac), .illegal_entry_qualifier(ill),
        .page_fail_hold(hold), .pf_word(pfw));
    task automatic stop_test();
        if (fail_count == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) begin
            fail_count++;
            stop_test();
        end
    endtask
    task automatic load(input logic [3:0] t, input logic [ADDR_W-1:0] a);
        @(posedge clk);
        setup <= 1'b1;
        sw <= {9'h000, t, a};
        @(posedge clk);
        setup <= 1'b0;
    endtask
    task automatic hit(input logic [ADDR_W-1:0] a, input logic [3:0] q, input logic e, input string n);
        @(posedge clk);
        rv <= 1'b1;
        va <= a;
        {rf, rr, rw, ru} <= q;
        @(posedge clk);
        rv <= 1'b0;
        #1;
        chk(n, 32'(e), 32'(pac));
        @(posedge clk);
        #1;
        chk("hold", 32'(e), 32'(hold));
    endtask
    task automatic ctl(input logic [3:0] c);
        @(posedge clk);
        {disp, abrt, ldf, fib} <= c;
        #1;
        chk("trap", 32'(c[2]), 32'(trap));
        @(posedge clk);
        {disp, abrt, ldf} <= 3'h0;
        #1;
    endtask
    task automatic t_reset();
        bus(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl", 32'(CTRL_RST), rdat);
        bus(1'b0, OFS_ADDR, 32'h0);
        chk("addr", 32'(ADDR_RST), rdat);
        bus(1'b1, OFS_FLAGS, 32'h3);
        bus(1'b0, OFS_FLAGS, 32'h0);
        chk("flags", 32'h0, rdat);
        bus(1'b0, 8'h14, 32'h0);
        chk("unmapped", 32'h0, rdat);
        hit(23'h0, 4'h0, 1'b0, "idle");
    endtask
    task automatic t_types();
        logic [3:0] t;
        logic [ADDR_W-1:0] a;
        for (int i = 0; i < 3; i++) begin
            t = (4'h8 >> i) | 4'h1;
            a = {5'(i + 1), 18'h2a5c3};
            load(t, a);
            bus(1'b0, OFS_CTRL, 32'h0);
            chk("ctrl", {28'h0, t[0], t[1], t[2], t[3]}, rdat);
            bus(1'b0, OFS_ADDR, 32'h0);
            chk("addr", {9'h0, a}, rdat);
            hit(a, t, 1'b1, "match");
            hit(a, t, 1'b1, "again");
            hit(a ^ 23'h1, t, 1'b0, "line");
            hit(a ^ 23'h400000, t, 1'b0, "section");
            hit(a, t ^ 4'h1, 1'b0, "user");
            hit(a, ((t >> 1) & 4'h6) | 4'h1, 1'b0, "type");
        end
    endtask
    task automatic t_flags();
        load(4'h3, 23'h000700);
        ctl(4'h2);
        chk("inh", 32'h0, 32'(inh));
        ctl(4'h3);
        chk("inh", 32'h1, 32'(inh));
        bus(1'b0, OFS_FLAGS, 32'h0);
        chk("flags", 32'h1, rdat);
        hit(23'h000700, 4'h3, 1'b0, "inhibit");
        ctl(4'h8);
        chk("flags", 32'h2, {30'h0, sup, inh});
        hit(23'h000700, 4'h3, 1'b0, "suppress");
        ctl(4'h8);
        chk("flags", 32'h0, {30'h0, sup, inh});
        hit(23'h000700, 4'h3, 1'b1, "resume");
        ctl(4'h3);
        ctl(4'h8);
        ctl(4'h4);
        chk("flags", 32'h1, {30'h0, sup, inh});
        bus(1'b0, OFS_FLAGS, 32'h0);
        chk("flags", 32'h1, rdat);
        ctl(4'h4);
        chk("flags", 32'h0, {30'h0, sup, inh});
        ctl(4'hb);
        chk("flags", 32'h0, {30'h0, sup, inh});
    endtask
    task automatic t_irq();
        bus(1'b0, OFS_STAT, 32'h0);
        chk("status", 32'h3, rdat);
        bus(1'b0, OFS_STAT, 32'h0);
        chk("status", 32'h0, rdat);
        bus(1'b1, OFS_MASK, 32'h1);
        hit(23'h000700, 4'h3, 1'b1, "irq hit");
        chk("irq", 32'h1, 32'(irq));
        bus(1'b1, OFS_MASK, 32'h2);
        chk("irq", 32'h0, 32'(irq));
        bus(1'b0, OFS_STAT, 32'h0);
        chk("status", 32'h1, rdat);
    endtask
    task automatic t_bus();
        bus(1'b0, OFS_MASK, 32'h0);
        chk("mask", 32'h2, rdat);
        bus(1'b1, OFS_ADDR, 32'h007fffff);
        bus(1'b0, OFS_ADDR, 32'h0);
        chk("addr", 32'h007fffff, rdat);
        sel <= 4'h1;
        bus(1'b1, OFS_ADDR, 32'hffffff00);
        sel <= 4'hf;
        bus(1'b0, OFS_ADDR, 32'h0);
        chk("addr", 32'h007fff00, rdat);
        bus(1'b1, OFS_CTRL, 32'h0000000f);
        bus(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl", 32'h0000000f, rdat);
    endtask
    initial begin
        {cyc, stb, we, setup, rv, rf, rr, rw, ru, disp, abrt, ldf, fib} = 13'h0000;
        adr = 8'h00;
        sel = 4'hf;
        wdat = 32'h0;
        sw = 36'h0;
        va = 23'h0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_types();
        t_flags();
        t_irq();
        t_bus();
        stop_test();
    end
endmodule // tb_abw_watch
